// ---- ldsd_pkg.sv ----
// ldsd_pkg: constants and carrier types for the line differential
// supervisor. assumes a 250 MHz core clock and 32-bit AHB-Lite access.
package ldsd_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_EVENT = 8'h08;
  localparam logic [7:0] REG_PICKUP = 8'h0C;
  localparam logic [7:0] REG_SLOPE1 = 8'h10;
  localparam logic [7:0] REG_SLOPE2 = 8'h14;
  localparam logic [7:0] REG_BREAK = 8'h18;
  // control fields
  localparam int CTL_DIFF_EN = 0;
  localparam int CTL_EVT_EN = 1;
  localparam int CTL_TGT_EN = 2;
  localparam int CTL_THREE = 3;
  localparam int CTL_DUAL = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SET_RST = 32'h0000_0000;
  // status fields
  localparam int STS_CHAN = 0;
  localparam int STS_ID = 2;
  localparam int STS_LOCK = 4;
  localparam int STS_BLK = 6;
  localparam int STS_TRIP = 7;
  localparam int STS_SLAVE = 8;
  localparam int STS_CFAIL = 9;
  // event bits
  localparam int EV_CHAN = 0;
  localparam int EV_LOCK = 1;
  localparam int EV_ID = 2;
  // lock status codes
  localparam logic [1:0] LK_SYNC = 2'h0;
  localparam logic [1:0] LK_GOOD = 2'h1;
  localparam logic [1:0] LK_SUSP = 2'h2;
  localparam logic [1:0] LK_FAIL = 2'h3;
  // timing in its own units
  localparam int CLK_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DOC = MS_NS / CLK_NS;
  localparam int SYNC_MIN_S = 5;
  localparam int SYNC_MAX_S = 7;
  localparam int LOCK_DELAY_MS_DOC = (SYNC_MIN_S + SYNC_MAX_S) * 500;
  localparam int WINDOW_S = 5;
  localparam int WINDOW_MS_DOC = WINDOW_S * 1000;
  localparam int RESYNC_MIN = 2;
  localparam int RESYNC_MS_DOC = RESYNC_MIN * 60000;
  localparam logic [2:0] TOL_PC = 3'h4;
  localparam logic [1:0] RELOCK_PC = 2'h3;
  // arithmetic
  localparam int QW = 64;
  localparam int SLOPE_FRAC = 15;
  // sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_CHECK = 8'h01,
    ST_STARTUP = 8'h02,
    ST_SYNC = 8'h04,
    ST_GOOD = 8'h08,
    ST_HOLD = 8'h10,
    ST_RELOCK = 8'h20,
    ST_SUSP = 8'h40,
    ST_FAIL = 8'h80
  } ldsd_state_t;
  // one terminal's phasor and error data, into-line positive
  typedef struct packed {
    logic signed [15:0] re;
    logic signed [15:0] im;
    logic signed [15:0] ps_re;
    logic signed [15:0] ps_im;
    logic [31:0] sumsq;
  } ldsd_term_t;
  // pin inputs from the channel side
  typedef struct packed {
    logic [1:0] chan_ok;
    logic [1:0] id_ok;
    logic peer_lost;
    logic lock_calc;
    logic err_ok;
    logic xfer_trip;
    logic pc_tick;
  } ldsd_pin_t;
endpackage

// ---- ldsd_top.sv ----
// ldsd_top: channel supervision, lock sequencer and trip decision.
// assumes channel pins are asynchronous, phasor data is on core_clk_in.
//
// Function
// - check channel, then send startup message
// - lock good about six seconds after start
// - peer power loss restarts the sequence
// - ride through four power-cycle interruptions
// - dual channel keeps working on one
// - five second window, relock after cycles
// - late return fails lock, long resync
// - three terminal one loss: master-slave
// - slave suspends differential, trips on transfer
// - restored channel relocks, back to master-master
// - two channels lost fails lock, resync
// - readable flags, events and targets gated
// - blocked on channel failure
// - blocked when lock failed or suspended
// - blocked on channel identity mismatch
// - trip when operate squared exceeds restraint
// - into-line current counts positive
// - two terminal operate is sum squared
// - two terminal restraint with two slopes
// - error term from sums and phasor
// - three terminal operate is sum squared
// - differential disabled until synchronised
`timescale 1ns/100ps
module ldsd_top import ldsd_pkg::*; #(
  parameter int MS_CYCLES = MS_CYCLES_DOC,
  parameter int LOCK_DELAY_MS = LOCK_DELAY_MS_DOC,
  parameter int WINDOW_MS = WINDOW_MS_DOC,
  parameter int RESYNC_MS = RESYNC_MS_DOC
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire ldsd_pin_t pins_in,
  input wire logic sample_valid_in,
  input wire ldsd_term_t loc_in,
  input wire ldsd_term_t rem1_in,
  input wire ldsd_term_t rem2_in,
  output logic startup_msg_out,
  output logic [1:0] lock_status_out,
  output logic blocked_out,
  output logic trip_out,
  output logic slave_out,
  output logic target_out
);
  // all module state in one record
  typedef struct packed {
    ldsd_pin_t sy1, sy2, sy3, filt; // pin synchroniser and agreed value
    ldsd_state_t st;
    logic [31:0] pre;              // millisecond prescaler
    logic [31:0] ms;               // milliseconds since entering sync, or hold from good
    logic [1:0][2:0] dn;           // power cycles each channel is down
    logic [1:0] cfail;             // channel counted as failed
    logic [1:0] rlk;               // good lock calculations seen
    logic long_rs;                 // next resync is the long one
    logic startup;
    logic [31:0] ctrl, pickup, s1sq, s2sq, bpsq;
    logic [2:0] evt, prev;
    logic [31:0] hrdata;
    logic wpend;
    logic [7:0] waddr;
    logic trip, blocked, slave, target;
    logic [1:0] lock;
  } ldsd_reg_t;

  ldsd_reg_t q, d;

  // magnitude squared of a phasor
  function automatic logic [QW-1:0] mag2(input logic signed [17:0] re,
                                          input logic signed [17:0] im);
    logic [QW-1:0] a, b;
    // widen before squaring so no product bit is lost
    a = $unsigned(QW'(re) * QW'(re));
    b = $unsigned(QW'(im) * QW'(im));
    return a + b;
  endfunction

  // per-terminal slope term; at the breakpoint the low slope applies
  function automatic logic [QW-1:0] slope_term(input logic [QW-1:0] m2,
      input logic [QW-1:0] bp2, input logic [15:0] lo_sq,
      input logic [15:0] hi_sq);
    logic [QW-1:0] r;
    r = '0;
    if (m2 <= bp2) begin
      r = (m2 * QW'(lo_sq)) >> SLOPE_FRAC;
    end else begin
      r = (((m2 - bp2) * QW'(hi_sq)) >> SLOPE_FRAC) +
          ((bp2 * QW'(lo_sq)) >> SLOPE_FRAC);
    end
    return r;
  endfunction

  // error estimate of one terminal, never negative
  function automatic logic [QW-1:0] sigma(input ldsd_term_t t);
    logic signed [QW-1:0] dot, e;
    // sum of squares minus phaselet-phasor product
    dot = QW'(t.ps_re) * QW'(t.re) + QW'(t.ps_im) * QW'(t.im);
    e = $signed({32'h0000_0000, t.sumsq}) - dot;
    return e[QW-1] ? '0 : QW'($unsigned(e));
  endfunction

  // 18-bit sign extension for phasor sums
  function automatic logic signed [17:0] sx(input logic signed [15:0] v);
    return 18'(v);
  endfunction

  // configuration views
  logic diff_en, three, dual;
  assign diff_en = q.ctrl[CTL_DIFF_EN];
  assign three = q.ctrl[CTL_THREE];
  assign dual = q.ctrl[CTL_DUAL] & ~q.ctrl[CTL_THREE];
  // lock delay, the long one after a late channel return
  logic [31:0] sync_ms;
  assign sync_ms = q.long_rs ? 32'(RESYNC_MS) : 32'(LOCK_DELAY_MS);

  // channels in use and their health
  logic [1:0] used;
  logic chans_up, chan_fail_any, all_failed, id_bad;
  assign used = (three | dual) ? 2'h3 : 2'h1;
  assign chans_up = &(q.filt.chan_ok | ~used);
  assign chan_fail_any = |(q.cfail & used);
  assign all_failed = &(q.cfail | ~used);
  assign id_bad = |(~q.filt.id_ok & used);

  // trip arithmetic, into-line positive so through load cancels
  logic [QW-1:0] op2, rest2, bp2;
  logic signed [17:0] sre, sim;
  assign bp2 = QW'(q.bpsq);
  assign sre = sx(loc_in.re) + sx(rem1_in.re) +
               (three ? sx(rem2_in.re) : 18'sh0);
  assign sim = sx(loc_in.im) + sx(rem1_in.im) +
               (three ? sx(rem2_in.im) : 18'sh0);
  assign op2 = mag2(sre, sim);
  assign rest2 = (QW'(q.pickup) << 1) + sigma(loc_in) + sigma(rem1_in) +
    slope_term(mag2(sx(loc_in.re), sx(loc_in.im)), bp2, q.s1sq[15:0],
               q.s2sq[15:0]) +
    slope_term(mag2(sx(rem1_in.re), sx(rem1_in.im)), bp2, q.s1sq[15:0],
               q.s2sq[15:0]) +
    (three ? sigma(rem2_in) +
      slope_term(mag2(sx(rem2_in.re), sx(rem2_in.im)), bp2,
                 q.s1sq[15:0], q.s2sq[15:0]) : '0);

  // bus address phase
  logic acc;
  assign acc = hsel_in & htrans_in[1] & hready_in;

  // next-state logic for everything
  always_comb begin
    logic tick, calc, ms_tick;
    logic [2:0] flags;
    tick = 1'b0;
    calc = 1'b0;
    ms_tick = 1'b0;
    flags = '0;
    d = q;
    // pin synchroniser; first stage feeds only the second
    d.sy1 = pins_in;
    d.sy2 = q.sy1;
    d.sy3 = q.sy2;
    if (q.sy2 == q.sy3) begin
      d.filt = q.sy3;
    end
    tick = d.filt.pc_tick & ~q.filt.pc_tick;
    calc = d.filt.lock_calc & ~q.filt.lock_calc;
    // free-running millisecond base
    ms_tick = (q.pre == 32'(MS_CYCLES - 1));
    d.pre = ms_tick ? '0 : q.pre + 32'h1;
    if (ms_tick) begin
      d.ms = q.ms + 32'h1;
    end
    d.startup = 1'b0;
    // channel interruption counters
    for (int i = 0; i < 2; i++) begin
      if (q.filt.chan_ok[i]) begin
        d.dn[i] = '0;
        d.cfail[i] = 1'b0;
      end else if (tick) begin
        // only the fifth lost cycle counts as failure
        if (q.dn[i] < TOL_PC) begin
          d.dn[i] = q.dn[i] + 3'h1;
        end else begin
          d.cfail[i] = 1'b1;
        end
      end
    end
    // lock sequencer
    case (q.st)
      ST_CHECK: begin
        // startup only on a good channel
        if (chans_up) begin
          d.st = ST_STARTUP;
          d.startup = 1'b1;
        end
      end
      ST_STARTUP: begin
        d.st = ST_SYNC;
        d.ms = '0;
        d.long_rs = 1'b0;
      end
      ST_SYNC: begin
        if (!chans_up) begin
          d.st = ST_FAIL;
        end else if (q.ms >= sync_ms) begin
          d.st = ST_GOOD;
          d.long_rs = 1'b0;
        end
      end
      ST_GOOD: begin
        if (three) begin
          if (all_failed) begin
            d.st = ST_FAIL;
          end else if (chan_fail_any) begin
            d.st = ST_SUSP;
          end
        end else if (all_failed) begin
          d.st = ST_HOLD;
          d.ms = '0;
        end
      end
      ST_HOLD: begin
        if (!all_failed) begin
          d.st = ST_RELOCK;
          d.rlk = '0;
        end else if (q.ms >= 32'(WINDOW_MS)) begin
          d.st = ST_FAIL;
          d.long_rs = 1'b1;
        end
      end
      ST_RELOCK: begin
        if (three ? chan_fail_any : all_failed) begin
          d.st = three ? ST_SUSP : ST_HOLD;
        end else if (calc) begin
          if (!q.filt.err_ok) begin
            d.rlk = '0;
          end else if (q.rlk == RELOCK_PC - 2'h1) begin
            d.st = ST_GOOD;
          end else begin
            d.rlk = q.rlk + 2'h1;
          end
        end
      end
      ST_SUSP: begin
        if (all_failed) begin
          d.st = ST_FAIL;
        end else if (!chan_fail_any) begin
          d.st = ST_RELOCK;
          d.rlk = '0;
        end
      end
      ST_FAIL: begin
        if (chans_up) begin
          d.st = ST_SYNC;
          d.ms = '0;
        end
      end
      default: begin
        d.st = ST_CHECK;
      end
    endcase
    // a peer power loss starts over
    if (q.filt.peer_lost) begin
      d.st = ST_CHECK;
      d.long_rs = 1'b0;
      // no startup message toward a peer that is down
      d.startup = 1'b0;
    end
    // lock status code
    case (q.st)
      ST_GOOD: d.lock = LK_GOOD;
      ST_HOLD, ST_RELOCK, ST_SUSP: d.lock = LK_SUSP;
      ST_FAIL: d.lock = LK_FAIL;
      default: d.lock = LK_SYNC;
    endcase
    d.blocked = diff_en & (chan_fail_any & (three | ~dual) | all_failed |
                           (q.st != ST_GOOD) | id_bad);
    d.slave = three & (q.st == ST_SUSP);
    // slaves trip only on transfer trip
    if (!diff_en) begin
      d.trip = 1'b0;
    end else if (three && q.st == ST_SUSP && q.filt.xfer_trip) begin
      d.trip = 1'b1;
    end else if (d.blocked) begin
      d.trip = 1'b0;
    end else if (sample_valid_in) begin
      d.trip = op2 > rest2;
    end
    flags = {~id_bad, q.st == ST_GOOD, chans_up};
    d.prev = flags;
    d.target = q.ctrl[CTL_TGT_EN] & ~&flags;
    // bus data phase write; hardware set wins over clear
    d.wpend = acc & hwrite_in;
    if (acc) begin
      d.waddr = haddr_in[7:0];
    end
    if (q.wpend) begin
      case (q.waddr)
        REG_CTRL: d.ctrl = hwdata_in;
        REG_EVENT: d.evt = q.evt & ~hwdata_in[2:0];
        REG_PICKUP: d.pickup = hwdata_in;
        REG_SLOPE1: d.s1sq = {16'h0000, hwdata_in[15:0]};
        REG_SLOPE2: d.s2sq = {16'h0000, hwdata_in[15:0]};
        REG_BREAK: d.bpsq = hwdata_in;
        default: d.ctrl = q.ctrl;
      endcase
    end
    if (q.ctrl[CTL_EVT_EN]) begin
      d.evt = d.evt | (flags ^ q.prev);
    end
    // bus read data, captured in the address phase
    if (acc && !hwrite_in) begin
      case (haddr_in[7:0])
        REG_CTRL: d.hrdata = q.ctrl;
        REG_STATUS: d.hrdata = 32'({q.cfail, q.slave, q.trip, q.blocked,
                                    q.lock, q.filt.id_ok, q.filt.chan_ok});
        REG_EVENT: d.hrdata = {29'h0, q.evt};
        REG_PICKUP: d.hrdata = q.pickup;
        REG_SLOPE1: d.hrdata = q.s1sq;
        REG_SLOPE2: d.hrdata = q.s2sq;
        REG_BREAK: d.hrdata = q.bpsq;
        default: d.hrdata = '0;
      endcase
    end
  end

  // state register, synchronous reset
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      q <= '0;
      q.st <= ST_CHECK;
      q.ctrl <= CTRL_RST;
      q.pickup <= SET_RST;
      q.s1sq <= SET_RST;
      q.s2sq <= SET_RST;
      q.bpsq <= SET_RST;
      q.lock <= LK_SYNC;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops; zero-wait OKAY slave
  assign hrdata_out = q.hrdata;
  assign hreadyout_out = rst_n_in | 1'b1;
  assign hresp_out = 1'b0;
  assign startup_msg_out = q.startup;
  assign lock_status_out = q.lock;
  assign blocked_out = q.blocked;
  assign trip_out = q.trip;
  assign slave_out = q.slave;
  assign target_out = q.target;

  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  startup_gate_a: assert property (
    $rose(q.startup) |-> $past(q.st == ST_CHECK) && $past(chans_up))
    else $error("startup sent without good channel");
  lock_delay_a: assert property (
    (q.st == ST_SYNC && q.ms < 32'(LOCK_DELAY_MS)) |=> q.st != ST_GOOD)
    else $error("lock declared before delay");
  power_loss_a: assert property (
    q.filt.peer_lost |=> q.st == ST_CHECK)
    else $error("peer power loss did not restart");
  tolerance_a: assert property (
    $rose(q.cfail[0]) |-> $past(q.dn[0]) == TOL_PC)
    else $error("channel failed before tolerance");
  dual_keep_a: assert property (
    (q.st == ST_GOOD && dual && !all_failed && !q.filt.peer_lost)
      |=> q.st == ST_GOOD)
    else $error("dual channel lost lock on one channel");
  window_a: assert property (
    (q.st == ST_HOLD && all_failed && !q.filt.peer_lost &&
     q.ms >= 32'(WINDOW_MS)) |=> q.st == ST_FAIL && q.long_rs)
    else $error("recovery window not enforced");
  split_a: assert property (
    (q.st == ST_GOOD && three && chan_fail_any && !all_failed &&
     !q.filt.peer_lost) |=> q.st == ST_SUSP ##1 q.slave)
    else $error("no master-slave fallback");
  blocked_lock_a: assert property (
    (diff_en && q.st != ST_GOOD) ##1 diff_en |-> blocked_out)
    else $error("not blocked while lock not good");
  trip_cmp_a: assert property (
    (diff_en && sample_valid_in && !d.blocked && !(three && q.st == ST_SUSP))
      |=> trip_out == $past(op2 > rest2))
    else $error("trip decision wrong");
  slave_xfer_a: assert property (
    (diff_en && three && q.st == ST_SUSP && q.filt.xfer_trip) |=> trip_out)
    else $error("slave ignored transfer trip");

  reach_good_c: cover property (q.st == ST_SYNC ##1 q.st == ST_GOOD);
  relock_c: cover property (q.st == ST_RELOCK ##1 q.st == ST_GOOD);
  suspend_c: cover property (q.st == ST_SUSP);
  trip_c: cover property ($rose(trip_out));
endmodule

// ---- ldsd_peer.sv ----
// ldsd_peer: remote relay model that drives the channel-side pins.
// assumes the bench steers links, ids, power state and transfer trip.
`timescale 1ns/100ps
module ldsd_peer import ldsd_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] link_in,
  input wire logic [1:0] id_in,
  input wire logic off_in,
  input wire logic xfer_trip_in,
  output ldsd_pin_t pins_out
);
  logic [3:0] ph_q; // power-cycle phase, 16 core cycles a cycle
  // free running time base, kept while links drop
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ph_q <= 4'h0;
    end else begin
      ph_q <= ph_q + 4'h1;
    end
  end
  // pulses last 4 cycles so the pin filter cannot lose them
  always_comb begin
    pins_out.chan_ok = link_in;
    pins_out.id_ok = id_in;
    pins_out.peer_lost = off_in;
    pins_out.pc_tick = ph_q < 4'h4;
    pins_out.lock_calc = (link_in != 2'h0) && (ph_q[3:2] == 2'h2);
    pins_out.err_ok = 1'b1;
    pins_out.xfer_trip = xfer_trip_in;
  end
endmodule

// ---- test_line_diff_sync_and_trip_decision.sv ----
// test bench: table of trip cases, then channel loss, relock, resync.
// assumes shortened timing parameters and one peer model on the pins.
`timescale 1ns/100ps
module test_line_diff_sync_and_trip_decision;
  import ldsd_pkg::*;
  localparam int LIMIT = 8000; // run ceiling in cycles
  // one trip case: settings, phasors, expected decision
  typedef struct packed {
    logic [31:0] p2, lo, hi, brk;
    logic signed [15:0] l, r, ps;
    logic [31:0] ss;
    logic exp;
  } ldsd_row_t;
  logic clk, rst_n, hsel, hwrite, smp, xfer, off, hrdy, hresp;
  logic [1:0] htrans, link, id, lk;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrd, v;
  logic sm, blk, trip, slave, tgt;
  ldsd_pin_t pins;
  ldsd_term_t loc, r1, r2;
  int fails, samples_checked, cyc, starts, n;
  ldsd_row_t rows [9];
  ldsd_peer peer (.clk_in(clk), .rst_n_in(rst_n), .link_in(link),
    .id_in(id), .off_in(off), .xfer_trip_in(xfer), .pins_out(pins));
  ldsd_top #(.MS_CYCLES(10), .LOCK_DELAY_MS(20), .WINDOW_MS(10),
    .RESYNC_MS(40)) dut (.core_clk_in(clk), .rst_n_in(rst_n),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hrdy), .hrdata_out(hrd), .hreadyout_out(hrdy),
    .hresp_out(hresp), .pins_in(pins), .sample_valid_in(smp),
    .loc_in(loc), .rem1_in(r1), .rem2_in(r2), .startup_msg_out(sm),
    .lock_status_out(lk), .blocked_out(blk), .trip_out(trip),
    .slave_out(slave), .target_out(tgt));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // startup pulses and the run ceiling
  always @(posedge clk) begin
    cyc++;
    if (sm === 1'b1) starts++;
    if (cyc == LIMIT) begin
      fails++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checked %0d failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // single AHB-Lite transfer, held until hready is seen high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    rd = hrd;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, v);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    bus(1'b0, a, 32'h0, v);
    check(nm, v, e);
  endtask
  task automatic set(input ldsd_row_t w);
    wr(REG_PICKUP, w.p2);
    wr(REG_SLOPE1, w.lo);
    wr(REG_SLOPE2, w.hi);
    wr(REG_BREAK, w.brk);
  endtask
  // one phasor sample, then time for the decision to land
  task automatic samp(input ldsd_row_t w, input logic signed [15:0] q);
    loc <= '{w.l, 16'sh0, w.ps, 16'sh0, w.ss};
    r1 <= '{w.r, 16'sh0, 16'sh0, 16'sh0, 32'h0};
    r2 <= '{q, 16'sh0, 16'sh0, 16'sh0, 32'h0};
    smp <= 1'b1;
    @(posedge clk);
    smp <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // cycles until lock good and unblocked, bounded
  task automatic wait_ok(input int mx);
    n = 0;
    while (!(lk === LK_GOOD && blk === 1'b0) && n < mx) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic drop(input logic [1:0] k, input int c);
    link <= k;
    repeat (c) @(posedge clk);
  endtask
  initial begin
    // pickup, low, high, break, local, remote, phaselet, squares, trip
    rows = '{
      '{32'h32, 32'h0, 32'h0, 32'h3E8, 16'shA, 16'sh0, 16'sh0, 32'h0, 0},
      '{32'h32, 32'h0, 32'h0, 32'h3E8, 16'shB, 16'sh0, 16'sh0, 32'h0, 1},
      '{32'h32, 32'h0, 32'h0, 32'h3E8, 16'shA, -16'shA, 16'sh0, 32'h0, 0},
      '{32'h32, 32'h0, 32'h0, 32'h3E8, 16'shA, 16'shA, 16'sh0, 32'h0, 1},
      '{32'h32, 32'h0, 32'h0, 32'h3E8, 16'shB, 16'sh0, 16'sh0, 32'h1E, 0},
      '{32'h32, 32'h0, 32'h0, 32'h3E8, 16'shB, 16'sh0, 16'sh1, 32'h1E, 1},
      '{32'h0, 32'h4000, 32'h0, 32'h3E8, 16'shA, -16'sh3, 16'sh0, 32'h0, 0},
      '{32'h0, 32'h4000, 32'hFFFF, 32'h40, 16'sh10, 16'sh0, 16'sh0, 32'h0,
        0},
      '{32'h32, 32'h0, 32'h0, 32'h3E8, 16'shA, 16'sh0, 16'sh14, 32'h0, 0}};
    {hsel, hwrite, smp, xfer, off} = 5'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    loc = '0;
    r1 = '0;
    r2 = '0;
    link = 2'h0;
    id = 2'h3;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    check("reset lock", lk, LK_SYNC);
    rst_n <= 1'b1;
    @(posedge clk);
    wr(REG_CTRL, 32'h7);
    rdc("ctrl", REG_CTRL, 32'h7);
    // no startup message while the channel is down
    repeat (40) @(posedge clk);
    check("early start", starts, 0);
    link <= 2'h3;
    n = 0;
    while (starts == 0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    // blocked during sync, lock after the delay
    check("sync blk", blk, 1'b1);
    wait_ok(400);
    check("sync time", n >= 185 && n <= 215, 1'b1);
    foreach (rows[i]) begin
      set(rows[i]);
      samp(rows[i], 16'sh7);
      check("trip row", trip, rows[i].exp);
    end
    rdc("status", REG_STATUS, 32'h1F);
    wr(8'h1C, 32'hFFFF_FFFF);
    rdc("unmapped", 8'h1C, 32'h0);
    check("okay resp", hresp, 1'b0);
    wr(REG_EVENT, 32'h7);
    rdc("event clear", REG_EVENT, 32'h0);
    id <= 2'h2;
    repeat (10) @(posedge clk);
    check("id blk", blk, 1'b1);
    id <= 2'h3;
    drop(2'h0, 40);
    drop(2'h3, 10);
    check("short blk", blk, 1'b0);
    check("short lock", lk, LK_GOOD);
    drop(2'h0, 120);
    check("fail blk", blk, 1'b1);
    check("target", tgt, 1'b1);
    bus(1'b0, REG_EVENT, 32'h0, v);
    check("chan event", v[EV_CHAN], 1'b1);
    link <= 2'h3;
    wait_ok(200);
    check("relock", n >= 30 && n <= 80, 1'b1);
    drop(2'h0, 300);
    check("late fail", lk, LK_FAIL);
    link <= 2'h3;
    wait_ok(800);
    check("resync", n >= 385 && n <= 425, 1'b1);
    off <= 1'b1;
    repeat (10) @(posedge clk);
    check("restart", lk, LK_SYNC);
    off <= 1'b0;
    wait_ok(400);
    check("new start", starts > 1, 1'b1);
    // dual channel keeps going on one link
    wr(REG_CTRL, 32'h17);
    drop(2'h2, 150);
    check("dual blk", blk, 1'b0);
    link <= 2'h3;
    wr(REG_CTRL, 32'hF);
    set(rows[0]);
    wait_ok(100);
    samp(rows[0], 16'sh7);
    check("three op", trip, 1'b1);
    drop(2'h2, 150);
    check("slave", slave, 1'b1);
    check("susp", lk, LK_SUSP);
    check("susp blk", blk, 1'b1);
    xfer <= 1'b1;
    repeat (8) @(posedge clk);
    samp(rows[0], 16'sh7);
    check("xfer trip", trip, 1'b1);
    xfer <= 1'b0;
    repeat (8) @(posedge clk);
    samp(rows[0], 16'sh7);
    check("no diff", trip, 1'b0);
    link <= 2'h3;
    wait_ok(200);
    check("relock3", n >= 30 && n <= 80, 1'b1);
    check("master", slave, 1'b0);
    drop(2'h0, 150);
    check("both fail", lk, LK_FAIL);
    link <= 2'h3;
    wait_ok(400);
    check("resync3", n >= 185 && n <= 225, 1'b1);
    // nothing flagged with function and targets off
    wr(REG_CTRL, 32'h8);
    drop(2'h0, 150);
    check("off blk", blk, 1'b0);
    check("target off", tgt, 1'b0);
    print_verdict();
  end
endmodule
